/* hw/pie_pkg.sv */
// Purpose: Constants for the product information store window
// Assumes: Configuration offsets are byte addresses, dword aligned
// Notes: Shared by the register window and the cycle sequencer
package pie_pkg;
	// Register offsets
	localparam logic [7:0] PIE_OFS_CTRL = 8'hD8;
	localparam logic [7:0] PIE_OFS_DATA = 8'hDC;
	localparam logic [7:0] PIE_OFS_DATA_MIRROR = 8'hEC;
	// Header word fields
	localparam logic [7:0] PIE_CAP_ID = 8'h03;
	localparam logic [7:0] PIE_NEXT_PTR = 8'hF0;
	localparam int PIE_CAP_LSB = 0;
	localparam int PIE_NEXT_LSB = 8;
	// Address and flag fields
	localparam int PIE_ADDR_W = 6;
	localparam int PIE_ADDR_LSB = 18;
	localparam int PIE_FLAG_BIT = 31;
	localparam int PIE_ADDR_BYTE = 2;
	localparam int PIE_FLAG_BYTE = 3;
	// Store location offset
	localparam int PIE_EE_ADDR_W = 8;
	localparam logic [7:0] PIE_EE_BASE = 8'h40;
	// Reset values
	localparam logic [5:0] PIE_ADDR_RESET = 6'h00;
	localparam logic PIE_FLAG_RESET = 1'b0;
	localparam logic [31:0] PIE_DATA_RESET = 32'h00000000;
	// Sequencer states
	typedef enum logic [1:0] {
		PIE_ST_IDLE = 2'b01,
		PIE_ST_WAIT = 2'b10
	} pie_state_e;
endpackage

/* hw/pie_cycle_seq.sv */
// Purpose: Runs one store read or write cycle per start pulse
// Assumes: The store controller answers on the same clock
// Notes: Holds the request until the acknowledge arrives
`timescale 1ns/1ps
`default_nettype none
module pie_cycle_seq import pie_pkg::*; #(
	parameter int ADDR_W = PIE_ADDR_W,
	parameter int EE_ADDR_W = PIE_EE_ADDR_W
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Command from the register window
	input wire logic start_in,
	input wire logic write_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	// Store controller side
	output logic ee_req_out,
	output logic ee_write_out,
	output logic [EE_ADDR_W-1:0] ee_addr_out,
	output logic [31:0] ee_wdata_out,
	input wire logic ee_ack_in,
	input wire logic [31:0] ee_rdata_in,
	// Completion back to the window
	output logic done_out,
	output logic [31:0] rdata_out,
	output logic busy_out
);
	pie_state_e state;
	pie_state_e next_state;
	wire ack_seen = (state == PIE_ST_WAIT) && ee_ack_in;

	if (EE_ADDR_W <= ADDR_W) begin : g_bad_width
		$error("store address too narrow for offset mapping");
	end

	assign busy_out = (state != PIE_ST_IDLE) || done_out;

	always_comb begin
		next_state = state;
		case (state)
			PIE_ST_IDLE: begin
				if (start_in) begin
					next_state = PIE_ST_WAIT;
				end
			end
			PIE_ST_WAIT: begin
				if (ee_ack_in) begin
					next_state = PIE_ST_IDLE;
				end
			end
			default: next_state = PIE_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= PIE_ST_IDLE;
			ee_req_out <= 1'b0;
			ee_write_out <= 1'b0;
			ee_addr_out <= '0;
			ee_wdata_out <= '0;
			done_out <= 1'b0;
			rdata_out <= '0;
		end else begin
			state <= next_state;
			done_out <= ack_seen;
			if (start_in && state == PIE_ST_IDLE) begin
				ee_req_out <= 1'b1;
				ee_write_out <= write_in;
				ee_addr_out <= EE_ADDR_W'(addr_in) + EE_ADDR_W'(PIE_EE_BASE);
				ee_wdata_out <= wdata_in;
			end else if (ack_seen) begin
				ee_req_out <= 1'b0;
			end
			if (ack_seen && !ee_write_out) begin
				rdata_out <= ee_rdata_in;
			end
		end
	end
endmodule
`default_nettype wire

/* hw/pie_window.sv */
// Purpose: Product information capability registers in configuration space
// Assumes: Store controller and configuration port share clk_in
// Notes: Commands arriving while a cycle runs are ignored
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Header word bits 7:0 read as fixed capability identifier 03h.
// - Header word bits 15:8 read as fixed next pointer F0h.
// - Writing address with flag 0 starts a store read at that address.
// - Flag stays 0 during read, becomes 1 when data is ready.
// - Writing address with flag 1 starts a store write of data register.
// - Flag stays 1 during write, clears to 0 once write finished.
// - Fetched data is shown in data register, mirrored at ECh.
// - Data register is 32-bit read-write, resets zero, low byte first.
// - Store location used is programmed address plus 40h.
// - Data register honours per-byte enables on reads and writes.
module pie_window import pie_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Configuration register port
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_rvalid_out,
	// Store controller port
	output logic ee_req_out,
	output logic ee_write_out,
	output logic [PIE_EE_ADDR_W-1:0] ee_addr_out,
	output logic [31:0] ee_wdata_out,
	input wire logic ee_ack_in,
	input wire logic [31:0] ee_rdata_in
);
	logic [PIE_ADDR_W-1:0] addr;
	logic flag;
	logic [31:0] data_word;
	logic [31:0] next_data_word;
	logic [31:0] ctrl_word;
	logic [31:0] read_word;
	logic [31:0] seq_rdata;
	logic seq_done;
	logic seq_busy;

	// Address decode
	wire [7:0] dw_addr = {cfg_addr_in[7:2], 2'b00};
	wire hit_ctrl = (dw_addr == PIE_OFS_CTRL);
	wire hit_data = (dw_addr == PIE_OFS_DATA);
	wire hit_mirror = (dw_addr == PIE_OFS_DATA_MIRROR);
	wire ctrl_wr = cfg_wr_in && hit_ctrl && !seq_busy;
	wire data_wr = cfg_wr_in && hit_data && !seq_busy;
	wire start = ctrl_wr && cfg_be_in[PIE_FLAG_BYTE];
	wire start_write = cfg_wdata_in[PIE_FLAG_BIT];
	wire addr_wr = ctrl_wr && cfg_be_in[PIE_ADDR_BYTE];
	wire [PIE_ADDR_W-1:0] next_addr = addr_wr ? cfg_wdata_in[PIE_ADDR_LSB +: PIE_ADDR_W] : addr;
	wire done_read = seq_done && !ee_write_out;

	// Control word layout, reserved bits zero
	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[PIE_CAP_LSB +: 8] = PIE_CAP_ID;
		ctrl_word[PIE_NEXT_LSB +: 8] = PIE_NEXT_PTR;
		ctrl_word[PIE_ADDR_LSB +: PIE_ADDR_W] = addr;
		ctrl_word[PIE_FLAG_BIT] = flag;
	end

	// Read selection
	assign read_word = hit_ctrl ? ctrl_word :
		(hit_data || hit_mirror) ? data_word : 32'h00000000;

	// Per-byte update of the data register
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign next_data_word[8*g +: 8] = done_read ? seq_rdata[8*g +: 8] :
			(data_wr && cfg_be_in[g]) ? cfg_wdata_in[8*g +: 8] :
			data_word[8*g +: 8];
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				data_word[8*g +: 8] <= PIE_DATA_RESET[8*g +: 8];
			end else begin
				data_word[8*g +: 8] <= next_data_word[8*g +: 8];
			end
		end
	end

	// Address and completion flag
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr <= PIE_ADDR_RESET;
			flag <= PIE_FLAG_RESET;
		end else begin
			addr <= next_addr;
			if (start) begin
				flag <= start_write;
			end else if (seq_done) begin
				flag <= !ee_write_out;
			end
		end
	end

	// Read answer, byte enables drop unselected lanes
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rdata_out <= 32'h00000000;
			cfg_rvalid_out <= 1'b0;
		end else begin
			cfg_rvalid_out <= cfg_rd_in;
			if (cfg_rd_in) begin
				cfg_rdata_out <= read_word & {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}},
					{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
			end
		end
	end

	pie_cycle_seq #(
		.ADDR_W(PIE_ADDR_W),
		.EE_ADDR_W(PIE_EE_ADDR_W)
	) u_seq (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(start),
		.write_in(start_write),
		.addr_in(next_addr),
		.wdata_in(data_word),
		.ee_req_out(ee_req_out),
		.ee_write_out(ee_write_out),
		.ee_addr_out(ee_addr_out),
		.ee_wdata_out(ee_wdata_out),
		.ee_ack_in(ee_ack_in),
		.ee_rdata_in(ee_rdata_in),
		.done_out(seq_done),
		.rdata_out(seq_rdata),
		.busy_out(seq_busy)
	);

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_read_start;
		start && !start_write;
	endsequence

	sequence s_write_start;
		start && start_write;
	endsequence

	sequence s_cycle_ack;
		ee_req_out && ee_ack_in;
	endsequence

	a_header_fixed: assert property (
		(cfg_rd_in && hit_ctrl && cfg_be_in[1:0] == 2'b11) |=>
		(cfg_rdata_out[15:0] == {PIE_NEXT_PTR, PIE_CAP_ID}))
		else $error("header word wrong");

	a_reserved_zero: assert property (
		(cfg_rd_in && hit_ctrl) |=> (cfg_rdata_out[17:16] == 2'b00 && cfg_rdata_out[30:24] == 7'h00))
		else $error("reserved control bits not zero");

	a_read_req_issued: assert property (
		s_read_start |=> (ee_req_out && !ee_write_out))
		else $error("read cycle not requested");

	a_read_flag_low: assert property (
		((ee_req_out || seq_done) && !ee_write_out) |-> !flag)
		else $error("flag rose during read");

	a_read_flag_set: assert property (
		(seq_done && !ee_write_out) |=> flag)
		else $error("flag not set after read");

	a_write_flag_high: assert property (
		s_write_start |=> (flag && ee_req_out && ee_write_out && ee_wdata_out == $past(data_word)))
		else $error("write cycle start wrong");

	a_write_flag_clear: assert property (
		(seq_done && ee_write_out) |=> !flag)
		else $error("flag not cleared after write");

	a_write_hold_flag: assert property (
		(ee_req_out && ee_write_out) |-> flag)
		else $error("flag dropped during write");

	a_read_data_load: assert property (
		(seq_done && !ee_write_out) |=> (data_word == $past(seq_rdata)))
		else $error("read data not loaded");

	a_store_offset: assert property (
		start |=> (ee_addr_out == {2'b01, $past(next_addr)}))
		else $error("store address not offset");

	a_byte_lane: assert property (
		(data_wr && cfg_be_in == 4'b0001) |=>
		(data_word[31:8] == $past(data_word[31:8]) && data_word[7:0] == $past(cfg_wdata_in[7:0])))
		else $error("byte enable not honoured");

	a_read_valid: assert property (
		cfg_rd_in |=> cfg_rvalid_out)
		else $error("read answer missing");

	a_read_lane_mask: assert property (
		(cfg_rd_in && hit_data && cfg_be_in == 4'h9) |=> (cfg_rdata_out[23:8] == 16'h0000))
		else $error("disabled read lanes not zero");

	a_mirror_read: assert property (
		(cfg_rd_in && hit_mirror && cfg_be_in == 4'hF) |=> (cfg_rdata_out == $past(data_word)))
		else $error("mirror read wrong");

	a_busy_addr_kept: assert property (
		(cfg_wr_in && hit_ctrl && seq_busy) |=> (addr == $past(addr)))
		else $error("address changed while busy");

	a_busy_data_kept: assert property (
		(cfg_wr_in && hit_data && seq_busy && !seq_done) |=> (data_word == $past(data_word)))
		else $error("data changed while busy");

	a_req_fields_hold: assert property (
		(ee_req_out && !ee_ack_in) |=>
		(ee_req_out && $stable(ee_addr_out) && $stable(ee_write_out) && $stable(ee_wdata_out)))
		else $error("store request not held");

	a_done_after_ack: assert property (
		s_cycle_ack |=> (seq_done && !ee_req_out))
		else $error("cycle not finished after acknowledge");
endmodule
`default_nettype wire

/* dv/pie_store_model.sv */
// Purpose: Store controller model answering word reads and writes
// Assumes: One request at a time, held until acknowledged
// Notes: Read data toggles outside the acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module pie_store_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Request side
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] lat_in,
	// Answer side
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [256];
	logic [3:0] cnt;
	initial for (int i = 0; i < 256; i++) mem[i] = 32'h5A000000 | (i * 32'h00010101);
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
			cnt <= 4'h0;
			rdata_out <= 32'hFFFFFFFF;
		end else begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out;
			if (req_in && !ack_out) begin
				if (cnt == lat_in) begin
					ack_out <= 1'b1;
					cnt <= 4'h0;
					rdata_out <= mem[addr_in];
					if (write_in) mem[addr_in] <= wdata_in;
				end else cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the product information window
// Assumes: Store model acknowledges after a settable delay
// Notes: Table rows cover plain register access
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in = 0, rst_n_in = 0, cfg_wr_in = 0, cfg_rd_in = 0, ee_ack_in;
	logic [7:0] cfg_addr_in = 8'h00, ee_addr_out;
	logic [3:0] cfg_be_in = 4'h0, lat = 4'h0;
	logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, ee_wdata_out, ee_rdata_in, v;
	logic cfg_rvalid_out, ee_req_out, ee_write_out;
	int n_fail = 0, n_checks = 0;
	typedef struct {logic [7:0] a; logic [3:0] wbe; logic [31:0] wd; logic [3:0] rbe; logic [31:0] exp;} pie_row_s;
	pie_row_s rows [6] = '{
		'{8'hDC, 4'hF, 32'h12345678, 4'hF, 32'h12345678},
		'{8'hDC, 4'h2, 32'hAABBCCDD, 4'hF, 32'h1234CC78},
		'{8'hDC, 4'h0, 32'h0, 4'h9, 32'h12000078},
		'{8'hD8, 4'h3, 32'hFFFFFFFF, 4'hF, 32'h0000F003},
		'{8'hEC, 4'hF, 32'h0, 4'hF, 32'h1234CC78},
		'{8'hE0, 4'hF, 32'hFFFFFFFF, 4'hF, 32'h0}
	};
	pie_window uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
		.cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
		.cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .ee_req_out(ee_req_out),
		.ee_write_out(ee_write_out), .ee_addr_out(ee_addr_out), .ee_wdata_out(ee_wdata_out),
		.ee_ack_in(ee_ack_in), .ee_rdata_in(ee_rdata_in));
	pie_store_model u_store (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(ee_req_out),
		.write_in(ee_write_out), .addr_in(ee_addr_out), .wdata_in(ee_wdata_out), .lat_in(lat),
		.ack_out(ee_ack_in), .rdata_out(ee_rdata_in));
	initial forever #25 clk_in = ~clk_in;
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cfg_wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
		@(posedge clk_in) #1;
		cfg_wr_in = 1;
		cfg_addr_in = a;
		cfg_be_in = be;
		cfg_wdata_in = d;
		@(posedge clk_in) #1;
		cfg_wr_in = 0;
	endtask
	task automatic cfg_rd(logic [7:0] a, logic [3:0] be);
		@(posedge clk_in) #1;
		cfg_rd_in = 1;
		cfg_addr_in = a;
		cfg_be_in = be;
		@(posedge clk_in) #1;
		cfg_rd_in = 0;
		chk("rvalid", cfg_rvalid_out, 1);
		v = cfg_rdata_out;
	endtask
	task automatic wait_flag(logic exp);
		for (int i = 0; i < 40; i++) begin
			cfg_rd(8'hD8, 4'hF);
			if (v[31] === exp) break;
		end
		chk("flag", v[31], exp);
	endtask
	task automatic stop_test;
		if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#150000;
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk_in);
		#1 rst_n_in = 1;
		cfg_rd(8'hD8, 4'hF);
		chk("header", v, 32'h0000F003);
		cfg_rd(8'hDC, 4'hF);
		chk("data reset", v, 32'h0);
		foreach (rows[i]) begin
			cfg_wr(rows[i].a, rows[i].wbe, rows[i].wd);
			cfg_rd(rows[i].a, rows[i].rbe);
			chk("row", v, rows[i].exp);
		end
		// Prompt read cycle at address 5
		cfg_wr(8'hD8, 4'hC, 32'h00140000);
		chk("req", ee_req_out, 1);
		chk("dir read", ee_write_out, 0);
		chk("ee addr", ee_addr_out, 8'h45);
		wait_flag(1);
		cfg_rd(8'hDC, 4'hF);
		chk("read data", v, 32'h5A454545);
		// Slow write cycle at address 3, data write while busy dropped
		lat = 4'h8;
		cfg_wr(8'hDC, 4'hF, 32'hCAFEF00D);
		cfg_wr(8'hD8, 4'hC, 32'h800C0000);
		chk("dir write", ee_write_out, 1);
		chk("ee wdata", ee_wdata_out, 32'hCAFEF00D);
		chk("ee addr", ee_addr_out, 8'h43);
		cfg_rd(8'hD8, 4'hF);
		chk("busy write", v, 32'h800CF003);
		cfg_wr(8'hDC, 4'hF, 32'h0);
		cfg_wr(8'hD8, 4'hC, 32'h00FC0000);
		wait_flag(0);
		chk("stored", u_store.mem[8'h43], 32'hCAFEF00D);
		cfg_rd(8'hD8, 4'hF);
		chk("busy cmd dropped", v, 32'h000CF003);
		chk("ee addr kept", ee_addr_out, 8'h43);
		cfg_rd(8'hDC, 4'hF);
		chk("data kept", v, 32'hCAFEF00D);
		// Address only, reserved bits, then read at stored top address
		cfg_wr(8'hD8, 4'h4, 32'h00FF0000);
		chk("no req", ee_req_out, 0);
		cfg_wr(8'hD8, 4'h8, 32'h7F000000);
		chk("ee addr", ee_addr_out, 8'h7F);
		cfg_rd(8'hD8, 4'hF);
		chk("busy read", v, 32'h00FCF003);
		wait_flag(1);
		cfg_rd(8'hEC, 4'hF);
		chk("mirror", v, 32'h5A7F7F7F);
		// Reset in the middle of a cycle
		cfg_wr(8'hD8, 4'hC, 32'h80FC0000);
		rst_n_in = 0;
		#1 chk("reset req", ee_req_out, 0);
		chk("reset dir", ee_write_out, 0);
		repeat (2) @(posedge clk_in);
		#1 rst_n_in = 1;
		cfg_rd(8'hD8, 4'hF);
		chk("reset header", v, 32'h0000F003);
		cfg_rd(8'hDC, 4'hF);
		chk("reset data", v, 32'h0);
		stop_test;
	end
endmodule
`default_nettype wire
